// File: src/soecr_pkg.sv
/*
 * Shared constants of the sequence-of-events input configuration and status bank:
 * register indices, bit positions, interrupt layout and timing figures.
 * Assumes a 32-bit APB slave whose registers sit at four times their index.
 */
`default_nettype none

package soecr_pkg;
	// Byte address width of the register window.
	localparam int AW = 8;
	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_CFG = 6'h0d;
	localparam logic [5:0] IDX_MASK = 6'h0e;
	localparam logic [5:0] IDX_IRQ_STS = 6'h0f;
	localparam logic [5:0] IDX_IRQ_MSK = 6'h10;
	// Bit positions of the configuration and status word.
	localparam int B_CFG = 0;
	localparam int B_FERR = 1;
	localparam int B_FUSE_EN = 6;
	localparam int B_FUSE = 7;
	localparam int B_AUX_EN = 8;
	localparam int B_AUX = 9;
	localparam int B_GND_EN = 10;
	localparam int B_GND = 11;
	localparam int B_CHAT_DIS = 12;
	localparam int B_CHAT_OPT = 13;
	localparam int B_SYNC = 14;
	// Writable configuration bits; all other bits are never stored.
	localparam logic [15:0] CFG_WR_MASK = 16'h3543;
	// Reset values of the configuration word and of the tagging mask.
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	// Interrupt status layout.
	localparam int IRQ_W = 3;
	localparam int IRQ_ATTN = 0;
	localparam int IRQ_CHAT = 1;
	localparam int IRQ_FERR = 2;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
	// Number of state changes between buffer reads that marks chatter.
	localparam logic [2:0] CHAT_LIM = 3'h4;
	// Chatter window in milliseconds and the clock rate in hertz.
	localparam int unsigned WIN_MS = 100;
	localparam int unsigned CLK_HZ = 10_000_000;
	// Number of field inputs passed through the synchroniser.
	localparam int NSYNC = 20;

	// Converts a register index to its byte address.
	function automatic logic [AW-1:0] reg_addr(input logic [5:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction : reg_addr
endpackage : soecr_pkg

`default_nettype wire

// File: src/soecr_regs.sv
/*
 * Configuration and status bank of a sixteen-channel sequence-of-events input
 * module: configuration/status word, event tagging mask, fault flags,
 * attention, chatter detection and event strobes, with an interrupt pair.
 * Assumes an APB master on pclk, field inputs asynchronous to pclk, and the
 * event buffer logic on pclk driving evbuf_read and evbuf_full.
 */
// Summary of operation
// RULE1: write config, read status at word thirteen
// RULE2: idle until configure bit set; status echoes
// RULE3: force error lights LED, blocks non-status reads
// RULE4: controller writes zero to unused config bits
// RULE5: bit six enables fuse signal and attention
// RULE6: status bit seven reports blown fuse
// RULE7: controller sets bit six on single-ended only
// RULE8: bit eight enables aux failure and ground circuitry
// RULE9: status bit nine reports aux voltage failure
// RULE10: bit ten enables ground attention; eleven flags
// RULE11: controller keeps bits eight to ten clear
// RULE12: chatter disabled records every unmasked change
// RULE13: chatter control bit resets to zero
// RULE14: option set: four changes between reads
// RULE15: option clear: two changes within window
// RULE16: status bit thirteen echoes chatter option
// RULE17: sixteen-bit tagging mask at word fourteen
// RULE18: enabled fault raises attention to controller
// RULE19: unused status bits read as zero
`default_nettype none

module soecr_regs
	import soecr_pkg::*;
#(
	parameter int unsigned WIN_CYC = WIN_MS * (CLK_HZ / 1000),
	parameter int NCH = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NCH-1:0] ch_in,
	input wire logic fuse_blown,
	input wire logic aux_fail,
	input wire logic gnd_fault,
	input wire logic clk_synced,
	input wire logic evbuf_read,
	input wire logic evbuf_full,
	output logic [NCH-1:0] ev_strobe,
	output logic [NCH-1:0] ch_state,
	output logic [NCH-1:0] chatter,
	output logic attention,
	output logic int_err_led,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.

	localparam int WIN_W = $clog2(WIN_CYC + 1);

	// Bus handshake states.
	typedef enum logic [1:0] {
		SOECR_IDLE = 2'b01,
		SOECR_ACC = 2'b10
	} soecr_state_t;

	soecr_state_t state; // Bus handshake state.
	logic [15:0] cfg; // Stored configuration word.
	logic [15:0] tag_mask; // Channel event tagging mask.
	logic [IRQ_W-1:0] irq_sts; // Sticky interrupt status.
	logic [IRQ_W-1:0] irq_msk; // Interrupt mask.
	logic [NSYNC-1:0] sync1; // First synchroniser stage.
	logic [NSYNC-1:0] sync2; // Second synchroniser stage.
	logic [2:0] chg_cnt [NCH]; // Changes since the last buffer read.
	logic [WIN_W-1:0] win_tmr [NCH]; // Window timer after a change.
	logic [15:0] sts; // Status word as read.
	logic [NCH-1:0] chg; // Channel changed this cycle.
	logic [NCH-1:0] hit; // Chatter detected this cycle.
	logic fuse_f; // Gated blown fuse.
	logic aux_f; // Gated auxiliary failure.
	logic gnd_f; // Gated ground fault.
	logic oper; // Module configured and not in forced error.
	logic next_attn; // Attention condition.
	logic sel_cfg; // Address decodes.
	logic sel_mask;
	logic sel_ists;
	logic sel_imsk;
	logic commit; // Access completes at this edge.
	logic wr; // Write completes at this edge.
	logic [31:0] next_rdata; // Read data for the access phase.
	logic next_err; // Error answer for the access phase.

	////////////////////////////////////////////////////////////////////////////
	// Field input synchroniser.

	// Two flops on every pin input; only sync2 is read by other logic.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else if (ce)
		begin
			sync1 <= {clk_synced, gnd_fault, aux_fail, fuse_blown, ch_in};
			sync2 <= sync1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status word and fault gating.

	// Fuse and aux faults are only seen while their enable bits are set; the ground fault while the aux enable bit is set.
	always_comb
	begin
		fuse_f = cfg[B_FUSE_EN] & sync2[NCH]; // RULE5 RULE6
		aux_f = cfg[B_AUX_EN] & sync2[NCH+1]; // RULE8 RULE9
		gnd_f = cfg[B_AUX_EN] & sync2[NCH+2]; // RULE8 RULE10
		oper = cfg[B_CFG] & ~cfg[B_FERR]; // RULE2
		next_attn = cfg[B_CFG] & (fuse_f | aux_f | (gnd_f & cfg[B_GND_EN])); // RULE18
		sts = '0; // RULE19
		sts[B_CFG] = cfg[B_CFG]; // RULE2
		sts[B_FERR] = cfg[B_FERR]; // RULE3
		sts[B_FUSE_EN] = cfg[B_FUSE_EN]; // RULE5
		sts[B_FUSE] = fuse_f; // RULE6
		sts[B_AUX_EN] = cfg[B_AUX_EN]; // RULE8
		sts[B_AUX] = aux_f; // RULE9
		sts[B_GND_EN] = cfg[B_GND_EN]; // RULE10
		sts[B_GND] = gnd_f; // RULE10
		sts[B_CHAT_DIS] = cfg[B_CHAT_DIS];
		sts[B_CHAT_OPT] = cfg[B_CHAT_OPT]; // RULE16
		sts[B_SYNC] = sync2[NCH+3];
	end

	////////////////////////////////////////////////////////////////////////////
	// APB decode and read mux.

	// Decodes the address and prepares read data and the error answer.
	always_comb
	begin
		sel_cfg = paddr == reg_addr(IDX_CFG);
		sel_mask = paddr == reg_addr(IDX_MASK);
		sel_ists = paddr == reg_addr(IDX_IRQ_STS);
		sel_imsk = paddr == reg_addr(IDX_IRQ_MSK);
		commit = ce & (state == SOECR_ACC) & psel & penable;
		wr = commit & pwrite;
		next_rdata = '0;
		next_err = 1'b0;
		if (sel_cfg)
		begin
			next_rdata[15:0] = sts; // RULE1
		end
		else if (sel_mask)
		begin
			// Under forced error only status words may be read.
			next_rdata[15:0] = cfg[B_FERR] & !pwrite ? '0 : tag_mask; // RULE17
			next_err = cfg[B_FERR] & !pwrite; // RULE3
		end
		else if (sel_ists)
		begin
			next_rdata[IRQ_W-1:0] = irq_sts;
		end
		else if (sel_imsk)
		begin
			next_rdata[IRQ_W-1:0] = cfg[B_FERR] & !pwrite ? '0 : irq_msk;
			next_err = cfg[B_FERR] & !pwrite; // RULE3
		end
		else
		begin
			// Unmapped addresses answer with an error.
			next_err = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB handshake: one wait state, answer registered.

	// The access phase is answered one cycle after it begins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= SOECR_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else if (ce)
		begin
			unique case (state)
				SOECR_IDLE:
				begin
					// Access phase seen: answer on the next edge.
					if (psel & penable)
					begin
						state <= SOECR_ACC;
						pready <= 1'b1;
						pslverr <= next_err;
						prdata <= pwrite ? '0 : next_rdata;
					end
				end
				SOECR_ACC:
				begin
					// Transfer completes; drop the answer.
					state <= SOECR_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
					prdata <= '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration, mask and interrupt mask registers.

	// Writes take effect at the completing edge, low byte lanes only.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg <= CFG_RST; // RULE13
			tag_mask <= MASK_RST;
			irq_msk <= '0;
		end
		else if (wr)
		begin
			if (sel_cfg)
			begin
				// Only defined bits are stored; unused bits stay zero.
				if (pstrb[0])
					cfg[7:0] <= pwdata[7:0] & CFG_WR_MASK[7:0]; // RULE1 RULE2 RULE3
				if (pstrb[1])
					cfg[15:8] <= pwdata[15:8] & CFG_WR_MASK[15:8]; // RULE8 RULE10
			end
			if (sel_mask)
			begin
				if (pstrb[0])
					tag_mask[7:0] <= pwdata[7:0]; // RULE17
				if (pstrb[1])
					tag_mask[15:8] <= pwdata[15:8]; // RULE17
			end
			if (sel_imsk & pstrb[0])
				irq_msk <= pwdata[IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Chatter detection and event strobes.

	// A change against the held state, counted only while operating.
	assign chg = (sync2[NCH-1:0] ^ ch_state) & {NCH{oper}};

	// Chatter hit per channel by the selected criterion.
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			if (cfg[B_CHAT_OPT])
				hit[i] = chg[i] & (chg_cnt[i] + 3'h1 >= CHAT_LIM); // RULE14
			else
				hit[i] = chg[i] & (win_tmr[i] != '0); // RULE15
			hit[i] = hit[i] & ~cfg[B_CHAT_DIS]; // RULE12
		end
	end

	// Counters, timers, flags and strobes per channel.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ch_state <= '0;
			chatter <= '0;
			ev_strobe <= '0;
			for (int i = 0; i < NCH; i++)
			begin
				chg_cnt[i] <= '0;
				win_tmr[i] <= '0;
			end
		end
		else if (ce)
		begin
			ch_state <= sync2[NCH-1:0];
			for (int i = 0; i < NCH; i++)
			begin
				// Change count restarts at each buffer read; a read wins, counting a same-cycle change.
				if (evbuf_read)
					chg_cnt[i] <= {2'b00, chg[i]};
				else if (chg[i] && chg_cnt[i] < CHAT_LIM)
					chg_cnt[i] <= chg_cnt[i] + 3'h1; // RULE14
				// Window timer restarts at every change.
				if (chg[i])
					win_tmr[i] <= WIN_W'(WIN_CYC - 1); // RULE15
				else if (win_tmr[i] != '0)
					win_tmr[i] <= win_tmr[i] - WIN_W'(1);
				// Chatter flag is sticky until a buffer read or chatter disable; set wins.
				if (hit[i])
					chatter[i] <= 1'b1;
				else if (evbuf_read | cfg[B_CHAT_DIS])
					chatter[i] <= 1'b0;
				// Unmasked, non-chattering changes become events while the buffer is not full.
				ev_strobe[i] <= chg[i] & ~tag_mask[i] & ~evbuf_full
					& ~chatter[i] & ~hit[i]; // RULE12
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Attention, error indicator and interrupt.

	// Attention and the internal error indicator are registered levels.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			attention <= 1'b0;
			int_err_led <= 1'b0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			attention <= next_attn; // RULE18
			int_err_led <= cfg[B_FERR]; // RULE3
			irq <= |(irq_sts & irq_msk);
		end
	end

	// Sticky status: hardware set wins over a write-one clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_sts <= IRQ_RST;
		else if (ce)
		begin
			for (int b = 0; b < IRQ_W; b++)
			begin
				if (wr && sel_ists && pstrb[0] && pwdata[b])
					irq_sts[b] <= 1'b0;
			end
			if (next_attn & ~attention)
				irq_sts[IRQ_ATTN] <= 1'b1;
			if (|hit)
				irq_sts[IRQ_CHAT] <= 1'b1;
			if (cfg[B_FERR] & ~int_err_led)
				irq_sts[IRQ_FERR] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking soecr_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_cfg_reads_status: assert property (ce && state == SOECR_IDLE && psel && penable
		&& !pwrite && sel_cfg |=> prdata[15:0] == $past(sts)) // RULE1
		else $error("config address read did not return status");
	chk_idle_no_events: assert property (!cfg[B_CFG] |-> ##1 ev_strobe == '0) // RULE2
		else $error("event while module not configured");
	chk_ferr_led: assert property ($rose(cfg[B_FERR]) && ce |=> int_err_led) // RULE3
		else $error("forced error did not light indicator");
	chk_ferr_read_block: assert property (ce && state == SOECR_IDLE && psel && penable
		&& !pwrite && sel_mask && cfg[B_FERR] |=> pslverr && prdata == '0) // RULE3
		else $error("mask readable under forced error");
	chk_fuse_gate: assert property (!cfg[B_FUSE_EN] |-> !sts[B_FUSE]) // RULE5 RULE6
		else $error("fuse flag without enable");
	chk_aux_flag: assert property (cfg[B_AUX_EN] && sync2[NCH+1] |-> sts[B_AUX]) // RULE9
		else $error("aux failure not reported");
	chk_gnd_attn: assert property (ce && cfg[B_CFG] && gnd_f && cfg[B_GND_EN]
		|=> attention) // RULE10 RULE18
		else $error("ground fault gave no attention");
	chk_chat_disabled: assert property (cfg[B_CHAT_DIS] |-> ##1 chatter == '0) // RULE12
		else $error("chatter flagged while disabled");
	chk_cnt_limit: assert property (ce && !cfg[B_CHAT_DIS] && cfg[B_CHAT_OPT] && chg[0]
		&& !evbuf_read && chg_cnt[0] == 3'h3 |=> chatter[0]) // RULE14
		else $error("fourth change not flagged");
	chk_win_flag: assert property (ce && !cfg[B_CHAT_DIS] && !cfg[B_CHAT_OPT] && chg[0]
		&& win_tmr[0] != '0 |=> chatter[0] && !ev_strobe[0]) // RULE15
		else $error("second change in window not flagged");
	chk_mask_rw: assert property (wr && sel_mask && pstrb[1:0] == 2'b11
		|=> tag_mask == $past(pwdata[15:0])) // RULE17
		else $error("mask did not store written value");
	chk_unused_zero: assert property (sts[5:2] == '0 && !sts[15]) // RULE19
		else $error("unused status bit set");

	cov_event: cover property (ev_strobe != '0);
	cov_chatter: cover property ($rose(chatter[0]));
	cov_irq: cover property ($rose(irq));

endmodule : soecr_regs

`default_nettype wire

// File: testbench/soecr_ctl.sv
/*
 * Controller model: APB master for the register bank and reader of the event buffer.
 * Assumes the bench top module provides num_errors and finish_test.
 */
`default_nettype none

module soecr_ctl
	import soecr_pkg::*;
(
	input wire logic pclk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [AW-1:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	output logic evbuf_read
);
	timeunit 1ns;
	timeprecision 1ns;

	// The bus is idle at time zero.
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, evbuf_read} = '0;
		pstrb = 4'h3;
	end

	// One transfer; the request is held until pready is seen high.
	task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// A slave that never answers ends the run.
		if (n == 20)
		begin
			soe_input_config_status_regs_tb.num_errors++;
			soe_input_config_status_regs_tb.finish_test();
		end
	endtask : xfer

	// One-cycle pulse telling the bank that the event buffer was read.
	task automatic rd_buf();
		@(posedge pclk);
		evbuf_read <= 1'b1;
		@(posedge pclk);
		evbuf_read <= 1'b0;
	endtask : rd_buf
endmodule : soecr_ctl

`default_nettype wire

// File: testbench/soe_input_config_status_regs_tb.sv
/*
 * Self-checking bench of the configuration and status bank.
 * Assumes soecr_ctl as controller and a short chatter window of 20 cycles.
 */
`default_nettype none

module soe_input_config_status_regs_tb
	import soecr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [15:0] ch_in = '0;
	logic fuse_blown = 1'b0;
	logic aux_fail = 1'b0;
	logic gnd_fault = 1'b0;
	logic clk_synced = 1'b0;
	logic evbuf_full = 1'b0;
	logic ce = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, evbuf_read, attention, int_err_led, irq, e;
	logic [AW-1:0] paddr;
	logic [31:0] pwdata, prdata, r, s;
	logic [3:0] pstrb;
	logic [15:0] ev_strobe, ch_state, chatter, cfg, msk;
	int num_errors = 0;
	int samples_checked = 0;
	int evcnt = 0;
	int k;

	always #50 pclk = ~pclk;

	// Counts every recorded event pulse.
	always @(posedge pclk)
		evcnt <= evcnt + $countones(ev_strobe);

	soecr_regs #(.WIN_CYC(20)) i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ch_in, .fuse_blown, .aux_fail,
		.gnd_fault, .clk_synced, .evbuf_read, .evbuf_full, .ev_strobe, .ch_state, .chatter,
		.attention, .int_err_led, .irq);

	soecr_ctl i_ctl (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .evbuf_read);

	task automatic chk(input string nm, input logic [31:0] v, input logic [31:0] x);
		samples_checked++;
		if (v !== x)
		begin
			num_errors++;
			$display("FAIL %s exp %h seen %h", nm, x, v);
		end
	endtask : chk

	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// Status word expected for a configuration word and the present field levels.
	function automatic logic [31:0] exp_sts(input logic [15:0] c);
		exp_sts = 32'(c & CFG_WR_MASK);
		exp_sts[B_FUSE] = fuse_blown & c[B_FUSE_EN];
		exp_sts[B_AUX] = aux_fail & c[B_AUX_EN];
		exp_sts[B_GND] = gnd_fault & c[B_AUX_EN];
		exp_sts[B_SYNC] = clk_synced;
	endfunction : exp_sts

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		i_ctl.xfer(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [AW-1:0] a);
		i_ctl.xfer(1'b0, a, 32'h0, r, e);
	endtask : rd

	// Toggles channel k n times, gap plus one cycles apart; ne below zero skips the event count.
	task automatic evt(input int n, input int gap, input int ne, input logic ch);
		int e0;
		e0 = evcnt;
		repeat (n)
		begin
			@(posedge pclk);
			ch_in[k] <= ~ch_in[k];
			repeat (gap) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
		chk("state", 32'(ch_state), 32'(ch_in));
		if (ne >= 0)
			chk("events", 32'(evcnt - e0), 32'(ne));
		chk("chatter", 32'(chatter[k]), 32'(ch));
	endtask : evt

	initial
	begin
		k = $urandom(57688);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h34);
		chk("status", r, 32'h0);
		rd(8'h38);
		chk("mask", r, 32'h0);
		rd(8'h00);
		chk("unmapped", 32'(e), 32'h1);
		$display("test reset done");
		repeat (12)
		begin
			cfg = 16'($urandom) & CFG_WR_MASK;
			@(posedge pclk);
			{fuse_blown, aux_fail, gnd_fault, clk_synced} <= 4'($urandom);
			wr(8'h34, 32'(cfg));
			repeat (5) @(posedge pclk);
			s = exp_sts(cfg);
			rd(8'h34);
			chk("status", r, s);
			chk("led", 32'(int_err_led), 32'(cfg[B_FERR]));
			chk("attn", 32'(attention), 32'(cfg[0] & (s[7] | s[9] | (s[11] & cfg[10]))));
			msk = 16'($urandom);
			wr(8'h38, 32'(msk));
			rd(8'h38);
			chk("mask", r, cfg[B_FERR] ? 32'h0 : 32'(msk));
			chk("mask err", 32'(e), 32'(cfg[B_FERR]));
		end
		$display("test config done");
		@(posedge pclk);
		{fuse_blown, aux_fail, gnd_fault, clk_synced} <= 4'h0;
		wr(8'h34, 32'h0);
		wr(8'h3c, 32'h7);
		wr(8'h40, 32'h0);
		wr(8'h34, 32'h41);
		@(posedge pclk);
		fuse_blown <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(8'h3c);
		chk("irq status", r, 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		wr(8'h40, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq on", 32'(irq), 32'h1);
		wr(8'h3c, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 32'(irq), 32'h0);
		$display("test irq done");
		wr(8'h40, 32'h0);
		k = $urandom_range(15);
		// The random loop leaves a random tagging mask behind; unmask all channels.
		wr(8'h38, 32'h0);
		wr(8'h34, 32'h1);
		i_ctl.rd_buf();
		evt(2, 40, 2, 1'b0);
		evt(2, 5, -1, 1'b1);
		i_ctl.rd_buf();
		// The flag clears at the edge that sees the read pulse; look one edge later.
		@(posedge pclk);
		chk("chatter read", 32'(chatter[k]), 32'h0);
		wr(8'h38, 32'(1 << k));
		evt(1, 40, 0, 1'b0);
		wr(8'h38, 32'h0);
		wr(8'h34, 32'h2001);
		i_ctl.rd_buf();
		evt(3, 40, 3, 1'b0);
		evt(1, 40, -1, 1'b1);
		wr(8'h34, 32'h1001);
		i_ctl.rd_buf();
		evt(6, 3, 6, 1'b0);
		@(posedge pclk);
		evbuf_full <= 1'b1;
		evt(2, 40, 0, 1'b0);
		evbuf_full <= 1'b0;
		// With the clock enable low a channel change must not move any state.
		@(posedge pclk);
		ce <= 1'b0;
		ch_in[k] <= ~ch_in[k];
		s = 32'(evcnt);
		repeat (8) @(posedge pclk);
		chk("frozen", 32'(ch_state ^ ch_in), 32'(1 << k));
		chk("frozen events", 32'(evcnt) - s, 32'h0);
		ce <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("thawed events", 32'(evcnt) - s, 32'h1);
		wr(8'h34, 32'h0);
		evt(2, 40, 0, 1'b0);
		$display("test events done");
		finish_test();
	end
endmodule : soe_input_config_status_regs_tb

`default_nettype wire
